//--- src/synth_cfg_defs.svh
`ifndef SYNTH_CFG_DEFS_SVH
`define SYNTH_CFG_DEFS_SVH

`define WORD_W 24
`define ADDR2_DIVIDER 2'h0
`define ADDR2_REFSEL 2'h1
`define ADDR2_PUMP 2'h2
`define ADDR3_BANDWIDTH 3'h3
`define ADDR4_IF_FEEDBACK 4'h7
`define ADDR5_IF_REFERENCE 5'hf
`define ADDR6_TEST 6'h1f
`define BIT_DEFAULTS 23
`define BIT_PRESCALER 22
`define BIT_LOCK_SEL 21
`define BIT_REF_RATE 21
`define COMPARE_EVERY 8'h40
`define WINDOW_NS 10
`define CLK_PERIOD_NS 5
`define WINDOW_CYCLES ((`WINDOW_NS) / (`CLK_PERIOD_NS))
`define LOCK_RUN 3'h4
`define PRESCALE_HI 4'h8
`define PRESCALE_LO 4'h6
`define FRAC_MAX_LO 11'h780
`define FRAC_MAX_HI 11'h7b0

`endif

//--- src/synth_cfg_pkg.sv
package synth_cfg_pkg;
   typedef struct packed {
      logic use_builtin_defaults;
      logic prescaler_variant_select;
      logic lock_output_select;
      logic [3:0] rf_program_count;
      logic [2:0] rf_swallow_count;
      logic [10:0] rf_fraction_numerator;
   } divider_cfg_type;
   typedef struct packed {
      logic [1:0] if_default_select;
      logic reference_rate_select;
      logic [1:0] spur_scheme_select;
      logic [1:0] output_buffer_level;
      logic rf_section_on;
      logic if_section_on;
   } refsel_cfg_type;
   typedef struct packed {
      logic [8:0] if_program_count;
      logic [3:0] if_swallow_count;
      logic [8:0] if_reference_count;
   } if_counts_type;
   typedef enum logic [1:0] {LOCK_IDLE, LOCK_WAIT, LOCK_COMPARE} lock_state_type;
endpackage

//--- src/synth_serial_config_lock_detect.sv
// How it works
// - Serial data shifts into a 24-bit register on each serial clock rise.
// - Latch strobe rising edge copies the shifted word into one control register.
// - Trailing low address bits of the word choose the target register.
// - Address 00 selects divider word, 01 selects reference select word.
// - A lone divider word write retunes without rewriting other words.
// - Bit 23 set uses built-in IF counters, clear uses user counters.
// - Bit 21 set shows lock status, clear holds the lock output low.
// - Divide ratio is prescaler times program count plus swallow plus fraction.
// - Phases are compared once every 64th reference and feedback cycle.
// - Lock output drops as soon as a phase error exceeds 10 ns.
// - Lock output rises after four consecutive in-window comparisons.
// - Reference select bit picks 19.20 or 19.68 MHz for divider arithmetic.
// - Two-bit IF select picks one built-in IF counter set.
// - Address 10 selects pump word, 011 selects bandwidth word.
// - Words 4, 5 and 6 use codes 0111, 01111, 011111; 4 and 5 act without defaults, 6 is stored but unused.
`timescale 1ns/1ps
`include "synth_cfg_defs.svh"

module synth_serial_config_lock_detect (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic latch_strobe,
   input wire logic ref_edge,
   input wire logic fb_edge,
   output logic lock_indicator_out,
   output synth_cfg_pkg::divider_cfg_type divider_cfg,
   output synth_cfg_pkg::refsel_cfg_type refsel_cfg,
   output logic [1:0] if_pump_current,
   output logic [7:0] bandwidth_cfg,
   output synth_cfg_pkg::if_counts_type if_counts,
   output logic [4:0] prescaler_value,
   output logic [10:0] fraction_limit
);

   // ==========================================================
   // Serial shift register on the link clock.
   logic [`WORD_W-1:0] shift_ff;

   always_ff @(posedge serial_clk) begin
      shift_ff <= {shift_ff[`WORD_W-2:0], serial_data};
   end

   // ==========================================================
   // Latch strobe edge and word transfer into the system domain.
   logic [2:0] strobe_sync_ff;
   logic [`WORD_W-1:0] held_word_ff;
   logic strobe_rise;
   logic [`WORD_W-1:0] word_capture;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         strobe_sync_ff <= 3'h0;
      end else begin
         strobe_sync_ff <= {strobe_sync_ff[1:0], latch_strobe};
      end
   end

   // The shift word is quiet while the strobe is high, so sampling it two
   // stages after the strobe rise reads a settled value.
   always_ff @(posedge sys_clk) begin
      held_word_ff <= shift_ff;
   end

   assign strobe_rise = strobe_sync_ff[1] & ~strobe_sync_ff[2];
   assign word_capture = held_word_ff;

   // ==========================================================
   // Address decode.
   logic hit_divider;
   logic hit_refsel;
   logic hit_pump;
   logic hit_bandwidth;
   logic hit_if_feedback;
   logic hit_if_reference;
   logic hit_test;

   assign hit_divider = word_capture[1:0] == `ADDR2_DIVIDER;
   assign hit_refsel = word_capture[1:0] == `ADDR2_REFSEL;
   assign hit_pump = word_capture[1:0] == `ADDR2_PUMP;
   assign hit_bandwidth = word_capture[2:0] == `ADDR3_BANDWIDTH;
   assign hit_if_feedback = word_capture[3:0] == `ADDR4_IF_FEEDBACK;
   assign hit_if_reference = word_capture[4:0] == `ADDR5_IF_REFERENCE;
   assign hit_test = word_capture[5:0] == `ADDR6_TEST;

   // ==========================================================
   // Control registers.
   logic [`WORD_W-1:0] rf_divider_word_ff;
   logic [`WORD_W-1:0] ref_and_if_select_word_ff;
   logic [`WORD_W-1:0] if_pump_current_word_ff;
   logic [`WORD_W-1:0] loop_bandwidth_word_ff;
   logic [`WORD_W-1:0] if_feedback_counter_word_ff;
   logic [`WORD_W-1:0] if_reference_counter_word_ff;
   logic [`WORD_W-1:0] factory_test_word_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rf_divider_word_ff <= 24'h0;
         ref_and_if_select_word_ff <= 24'h0;
         if_pump_current_word_ff <= 24'h0;
         loop_bandwidth_word_ff <= 24'h0;
         if_feedback_counter_word_ff <= 24'h0;
         if_reference_counter_word_ff <= 24'h0;
         factory_test_word_ff <= 24'h0;
      end else if (strobe_rise) begin
         if (hit_divider) begin
            rf_divider_word_ff <= word_capture;
         end
         if (hit_refsel) begin
            ref_and_if_select_word_ff <= word_capture;
         end
         if (hit_pump) begin
            if_pump_current_word_ff <= word_capture;
         end
         if (hit_bandwidth) begin
            loop_bandwidth_word_ff <= word_capture;
         end
         if (hit_if_feedback) begin
            if_feedback_counter_word_ff <= word_capture;
         end
         if (hit_if_reference) begin
            if_reference_counter_word_ff <= word_capture;
         end
         if (hit_test) begin
            factory_test_word_ff <= word_capture;
         end
      end
   end

   // ==========================================================
   // Field decode and IF counter selection.
   synth_cfg_pkg::divider_cfg_type div_fields;
   synth_cfg_pkg::refsel_cfg_type ref_fields;
   synth_cfg_pkg::if_counts_type builtin_counts;
   synth_cfg_pkg::if_counts_type user_counts;
   synth_cfg_pkg::if_counts_type nxt_if_counts;
   logic [4:0] nxt_prescaler_value;
   logic [10:0] nxt_fraction_limit;

   assign div_fields = {rf_divider_word_ff[`BIT_DEFAULTS],
      rf_divider_word_ff[`BIT_PRESCALER], rf_divider_word_ff[`BIT_LOCK_SEL],
      rf_divider_word_ff[19:2]};
   assign ref_fields = {ref_and_if_select_word_ff[23:21], ref_and_if_select_word_ff[12:11],
      ref_and_if_select_word_ff[5:2]};
   assign user_counts = {if_feedback_counter_word_ff[12:4], if_feedback_counter_word_ff[16:13],
      if_reference_counter_word_ff[13:5]};
   assign builtin_counts = (ref_fields.if_default_select == 2'h0) ? {9'h058, 4'hf, 9'h0a0} :
      (ref_fields.if_default_select == 2'h1) ? {9'h0bf, 4'h4, 9'h0a0} :
      {9'h0e5, 4'h9, 9'h0a0};
   assign nxt_if_counts = div_fields.use_builtin_defaults ? builtin_counts : user_counts;
   assign nxt_prescaler_value = {1'b0, div_fields.prescaler_variant_select ?
      `PRESCALE_HI : `PRESCALE_LO};
   assign nxt_fraction_limit = ref_fields.reference_rate_select ?
      `FRAC_MAX_HI : `FRAC_MAX_LO;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         divider_cfg <= '0;
         refsel_cfg <= '0;
         if_pump_current <= 2'h0;
         bandwidth_cfg <= 8'h0;
         if_counts <= '0;
         prescaler_value <= 5'h0;
         fraction_limit <= 11'h0;
      end else begin
         divider_cfg <= div_fields;
         refsel_cfg <= ref_fields;
         if_pump_current <= if_pump_current_word_ff[23:22];
         bandwidth_cfg <= {loop_bandwidth_word_ff[23:19], loop_bandwidth_word_ff[4:3], 1'b0};
         if_counts <= nxt_if_counts;
         prescaler_value <= nxt_prescaler_value;
         fraction_limit <= nxt_fraction_limit;
      end
   end

   // ==========================================================
   // Lock detect: edge inputs are synchronised, counted and compared.
   logic [1:0] ref_sync_ff;
   logic [1:0] fb_sync_ff;
   logic ref_prev_ff;
   logic fb_prev_ff;
   logic ref_rise;
   logic fb_rise;
   logic [7:0] ref_count_ff;
   logic [7:0] fb_count_ff;
   logic ref_mark;
   logic fb_mark;
   synth_cfg_pkg::lock_state_type state_ff;
   logic [7:0] gap_ff;
   logic first_ref_ff;
   logic [2:0] good_run_ff;
   logic locked_ff;
   logic gap_wide;

   assign ref_rise = ref_sync_ff[1] & ~ref_prev_ff;
   assign fb_rise = fb_sync_ff[1] & ~fb_prev_ff;
   assign ref_mark = ref_rise && (ref_count_ff == `COMPARE_EVERY - 8'h1);
   assign fb_mark = fb_rise && (fb_count_ff == `COMPARE_EVERY - 8'h1);
   assign gap_wide = gap_ff > 8'(`WINDOW_CYCLES);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ref_sync_ff <= 2'h0;
         fb_sync_ff <= 2'h0;
         ref_prev_ff <= 1'b0;
         fb_prev_ff <= 1'b0;
         ref_count_ff <= 8'h0;
         fb_count_ff <= 8'h0;
      end else begin
         ref_sync_ff <= {ref_sync_ff[0], ref_edge};
         fb_sync_ff <= {fb_sync_ff[0], fb_edge};
         ref_prev_ff <= ref_sync_ff[1];
         fb_prev_ff <= fb_sync_ff[1];
         if (ref_rise) begin
            ref_count_ff <= ref_mark ? 8'h0 : ref_count_ff + 8'h1;
         end
         if (fb_rise) begin
            fb_count_ff <= fb_mark ? 8'h0 : fb_count_ff + 8'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_ff <= synth_cfg_pkg::LOCK_IDLE;
         gap_ff <= 8'h0;
         first_ref_ff <= 1'b0;
         good_run_ff <= 3'h0;
         locked_ff <= 1'b0;
      end else begin
         case (state_ff)
            synth_cfg_pkg::LOCK_IDLE: begin
               gap_ff <= 8'h0;
               if (ref_mark && fb_mark) begin
                  state_ff <= synth_cfg_pkg::LOCK_COMPARE;
               end else if (ref_mark || fb_mark) begin
                  first_ref_ff <= ref_mark;
                  state_ff <= synth_cfg_pkg::LOCK_WAIT;
               end
            end
            synth_cfg_pkg::LOCK_WAIT: begin
               if (gap_ff != 8'hff) begin
                  gap_ff <= gap_ff + 8'h1;
               end
               if ((first_ref_ff && fb_mark) || (!first_ref_ff && ref_mark)) begin
                  state_ff <= synth_cfg_pkg::LOCK_COMPARE;
               end else if (gap_wide) begin
                  good_run_ff <= 3'h0;
                  locked_ff <= 1'b0;
                  state_ff <= synth_cfg_pkg::LOCK_COMPARE;
               end
            end
            synth_cfg_pkg::LOCK_COMPARE: begin
               if (gap_wide) begin
                  good_run_ff <= 3'h0;
                  locked_ff <= 1'b0;
               end else if (good_run_ff == `LOCK_RUN - 3'h1) begin
                  locked_ff <= 1'b1;
               end else begin
                  good_run_ff <= good_run_ff + 3'h1;
               end
               state_ff <= synth_cfg_pkg::LOCK_IDLE;
            end
            default: begin
               state_ff <= synth_cfg_pkg::LOCK_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         lock_indicator_out <= 1'b0;
      end else begin
         lock_indicator_out <= locked_ff & div_fields.lock_output_select;
      end
   end

endmodule

//--- test/synth_host_model.sv
`timescale 1ns/1ps
// ====
// Serial host: link clock runs only inside a frame.
module synth_host_model (
   output logic serial_clk,
   output logic serial_data,
   output logic latch_strobe
);
   initial begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      latch_strobe = 1'b0;
   end
   task automatic send(input logic [23:0] word);
      #1.3;
      for (int i = 23; i >= 0; i--) begin
         serial_data = word[i];
         #6 serial_clk = 1'b1;
         #6 serial_clk = 1'b0;
      end
      serial_data = ~word[0];
      #20 latch_strobe = 1'b1;
      #25 latch_strobe = 1'b0;
      #25;
   endtask
endmodule

//--- test/synth_serial_config_lock_detect_sva.sv
`timescale 1ns/1ps
// ====
// Checker on the configuration and lock outputs.
module synth_cfg_checker (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic latch_strobe,
   input wire logic lock_indicator_out,
   input wire synth_cfg_pkg::divider_cfg_type divider_cfg,
   input wire synth_cfg_pkg::refsel_cfg_type refsel_cfg,
   input wire synth_cfg_pkg::if_counts_type if_counts,
   input wire logic [4:0] prescaler_value,
   input wire logic [10:0] fraction_limit
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic [11:0] low_cnt_ff;
   wire [1:0] if_sel = refsel_cfg.if_default_select;
   wire [21:0] builtin = if_sel == 2'h0 ? {9'h058, 4'hf, 9'h0a0} :
      if_sel == 2'h1 ? {9'h0bf, 4'h4, 9'h0a0} : {9'h0e5, 4'h9, 9'h0a0};
   always_ff @(posedge sys_clk) begin
      if (srst || lock_indicator_out) begin
         low_cnt_ff <= 12'h000;
      end else if (low_cnt_ff != 12'hfff) begin
         low_cnt_ff <= low_cnt_ff + 12'h001;
      end
   end
   sequence strobe_rise_s;
      !latch_strobe ##1 latch_strobe;
   endsequence
   sequence cfg_quiet_s;
      $stable(divider_cfg) && $stable(refsel_cfg);
   endsequence
   AST_COMMIT_WAIT: assert property (strobe_rise_s |-> cfg_quiet_s [*2])
      else $error("config changed too soon after strobe");
   AST_CFG_HOLD: assert property (!latch_strobe [*8] |-> cfg_quiet_s)
      else $error("config changed with strobe low");
   AST_LOCK_OFF: assert property (!divider_cfg.lock_output_select [*3] |-> !lock_indicator_out)
      else $error("lock high while output disabled");
   AST_LOCK_RUN: assert property ($rose(lock_indicator_out)
      && $past(divider_cfg.lock_output_select, 3) |-> low_cnt_ff >= 12'h180)
      else $error("lock rose too early");
   AST_PRESCALE: assert property (($stable(divider_cfg) && divider_cfg.rf_program_count != 4'h0)
      [*2] |-> prescaler_value == (divider_cfg.prescaler_variant_select ? 5'h08 : 5'h06))
      else $error("prescaler value wrong");
   AST_FRAC_LIMIT: assert property (($stable(refsel_cfg) && refsel_cfg.rf_section_on) [*2]
      |-> fraction_limit == (refsel_cfg.reference_rate_select ? 11'h7b0 : 11'h780))
      else $error("fraction limit wrong");
   AST_IF_BUILTIN: assert property (($stable(refsel_cfg) && $stable(divider_cfg)
      && divider_cfg.use_builtin_defaults) [*2] |-> if_counts == builtin)
      else $error("builtin counters wrong");
   AST_RESET_LOW: assert property ($fell(srst) |-> !lock_indicator_out && divider_cfg == 21'h0)
      else $error("outputs not cleared by reset");
endmodule
bind synth_serial_config_lock_detect synth_cfg_checker i_chk (.sys_clk(sys_clk), .srst(srst),
   .latch_strobe(latch_strobe), .lock_indicator_out(lock_indicator_out),
   .divider_cfg(divider_cfg), .refsel_cfg(refsel_cfg), .if_counts(if_counts),
   .prescaler_value(prescaler_value), .fraction_limit(fraction_limit));

//--- test/tb_synth_serial_config_lock_detect.sv
`timescale 1ns/1ps
// ====
// Bench: serial programming and lock detection.
module tb_synth_serial_config_lock_detect;
   localparam logic [23:0] bw_word = {5'h13, 14'h2f46, 2'h3, 3'h3};
   localparam logic [23:0] pump_word = {2'h2, 22'h09da8a};
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic ref_edge = 1'b0;
   logic fb_edge = 1'b0;
   logic [7:0] ph_ff = 8'h00;
   logic [7:0] skew = 8'h00;
   wire [7:0] fb_ph = ph_ff - skew;
   wire serial_clk, serial_data, latch_strobe, lock_indicator_out;
   wire synth_cfg_pkg::divider_cfg_type divider_cfg;
   wire synth_cfg_pkg::refsel_cfg_type refsel_cfg;
   wire synth_cfg_pkg::if_counts_type if_counts;
   wire [1:0] pump;
   wire [7:0] bw;
   wire [4:0] presc;
   wire [10:0] flim;
   int fail_count = 0;
   int checks = 0;
   int n;
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      ph_ff <= ph_ff + 8'h01;
      ref_edge <= ph_ff[2];
      fb_edge <= fb_ph[2];
   end
   synth_host_model i_host (.serial_clk(serial_clk), .serial_data(serial_data),
      .latch_strobe(latch_strobe));
   synth_serial_config_lock_detect i_dut (.sys_clk(sys_clk), .srst(srst),
      .serial_clk(serial_clk), .serial_data(serial_data), .latch_strobe(latch_strobe),
      .ref_edge(ref_edge), .fb_edge(fb_edge), .lock_indicator_out(lock_indicator_out),
      .divider_cfg(divider_cfg), .refsel_cfg(refsel_cfg), .if_pump_current(pump),
      .bandwidth_cfg(bw), .if_counts(if_counts), .prescaler_value(presc),
      .fraction_limit(flim));
   function automatic logic [23:0] w0(logic [2:0] f, logic [3:0] b, logic [2:0] a,
      logic [10:0] fn);
      return {f, 1'b0, b, a, fn, 2'h0};
   endfunction
   function automatic logic [23:0] w1(logic [1:0] sel, logic osc);
      return {sel, osc, 1'b1, 7'h00, 2'h2, 2'h0, 3'h5, 2'h3, 2'h3, 2'h1};
   endfunction
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic settle();
      repeat (12) @(negedge sys_clk);
   endtask
   task automatic conclude();
      if (fail_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wait_lock(input logic lvl, input int lim);
      n = 0;
      while (lock_indicator_out !== lvl && n < lim) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= lim) begin
         chk("lock", lvl, lock_indicator_out);
         conclude();
      end
   endtask
   task automatic t_start();
      chk("lock", 1'b0, lock_indicator_out);
      i_host.send(bw_word);
      i_host.send(pump_word);
      i_host.send(w1(2'h1, 1'b0));
      i_host.send(w0(3'h7, 4'h2, 3'h1, 11'h000));
      settle();
      chk("bw", 8'h9e, bw);
      chk("pump", 2'h2, pump);
      chk("refsel", {2'h1, 1'b0, 2'h2, 2'h3, 2'h3}, refsel_cfg);
      chk("divider", {3'h7, 4'h2, 3'h1, 11'h000}, divider_cfg);
      chk("presc", 5'h08, presc);
   endtask
   task automatic t_select();
      logic [21:0] tbl [3] = '{{9'h058, 4'hf, 9'h0a0}, {9'h0bf, 4'h4, 9'h0a0},
         {9'h0e5, 4'h9, 9'h0a0}};
      for (int s = 0; s < 3; s++) begin
         i_host.send(w1(2'(s), s[0]));
         settle();
         chk("ifcnt", tbl[s], if_counts);
         chk("flim", s[0] ? 11'h7b0 : 11'h780, flim);
      end
   endtask
   task automatic t_retune();
      i_host.send(w0(3'h5, 4'hf, 3'h5, 11'h77f));
      settle();
      chk("divider", {3'h5, 4'hf, 3'h5, 11'h77f}, divider_cfg);
      chk("presc", 5'h06, presc);
      chk("refsel", {2'h2, 1'b0, 2'h2, 2'h3, 2'h3}, refsel_cfg);
   endtask
   task automatic t_custom();
      i_host.send({1'b1, 18'h00000, 5'h1f});
      i_host.send({10'h0c2, 9'h002, 5'h0f});
      i_host.send({7'h08, 4'h3, 9'h100, 4'h7});
      i_host.send(bw_word);
      i_host.send(pump_word);
      i_host.send(w1(2'h0, 1'b1));
      i_host.send(w0(3'h1, 4'h2, 3'h1, 11'h7af));
      settle();
      chk("ifcnt", {9'h100, 4'h3, 9'h002}, if_counts);
      i_host.send({18'h3ffff, 6'h3f});
      settle();
      chk("ifcnt", {9'h100, 4'h3, 9'h002}, if_counts);
      chk("divider", {3'h1, 4'h2, 3'h1, 11'h7af}, divider_cfg);
   endtask
   task automatic t_lock();
      wait_lock(1'b1, 4000);
      skew = 8'h04;
      wait_lock(1'b0, 600);
      skew = 8'h00;
      // A skew step leaves the feedback count off by an edge, so reset realigns both counters.
      @(posedge sys_clk);
      srst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      @(negedge sys_clk);
      chk("lockrst", 1'b0, lock_indicator_out);
      chk("divrst", 21'h0, divider_cfg);
      i_host.send(w0(3'h1, 4'h2, 3'h1, 11'h000));
      wait_lock(1'b1, 2600);
      chk("lockrun", 1'b1, n >= 1536);
      i_host.send(w0(3'h4, 4'h2, 3'h1, 11'h000));
      repeat (600) @(negedge sys_clk);
      chk("lockoff", 1'b0, lock_indicator_out);
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      @(negedge sys_clk);
      t_start();
      t_select();
      t_retune();
      t_custom();
      t_lock();
      conclude();
   end
endmodule
